// *** cvmc_pkg.sv ***
package cvmc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_LEVEL_RAMP_AND_MIXING = 8'h03;
	localparam logic [7:0] ADDR_CHANNEL_A_ATTENUATION = 8'h04;
	localparam logic [7:0] ADDR_CHANNEL_B_ATTENUATION = 8'h05;
	localparam logic [7:0] ADDR_ADC_SETTINGS = 8'h06;
	localparam logic [7:0] ADDR_SECOND_MODE_SETTINGS = 8'h07;
	localparam logic [7:0] ADDR_DEVICE_IDENTITY = 8'h08;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_LEVEL_RAMP_AND_MIXING = 8'h29;
	localparam logic [7:0] RST_CHANNEL_ATTENUATION = 8'h00;
	localparam logic [7:0] RST_ADC_SETTINGS = 8'h00;
	localparam logic [7:0] RST_SECOND_MODE_SETTINGS = 8'h01;

	// Arbitrary identity values, not tied to any product
	localparam logic [3:0] PART_CODE = 4'hA;
	localparam logic [3:0] REVISION_CODE = 4'h5;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MIX_LINK_BIT = 6;
	localparam int RAMP_MODE_MSB = 5;
	localparam int RAMP_MODE_LSB = 4;
	localparam int MIX_A_MSB = 3;
	localparam int MIX_A_LSB = 2;
	localparam int MIX_B_MSB = 1;
	localparam int MIX_B_LSB = 0;
	localparam int ATT_MUTE_BIT = 7;
	localparam int ATT_MSB = 6;
	localparam int SHORT_WORD_DITHER_BIT = 5;
	localparam int ADC_FORMAT_BIT = 4;
	localparam int ADC_SILENCE_FIRST_BIT = 3;
	localparam int ADC_SILENCE_SECOND_BIT = 2;
	localparam int OFFSET_HOLD_FIRST_BIT = 1;
	localparam int OFFSET_HOLD_SECOND_BIT = 0;
	localparam int LOOPBACK_BIT = 4;
	localparam int LINKED_MUTE_INDICATOR_BIT = 3;
	localparam int FREEZE_BIT = 2;
	localparam int HOST_PORT_ENABLE_BIT = 1;
	localparam int LOW_POWER_REQUEST_BIT = 0;

	// ----------------------------------------
	// Level engine
	// ----------------------------------------
	localparam int SAMPLE_W = 24;
	localparam int LEVEL_W = 10;
	localparam int EIGHTHS_PER_DB = 8;
	localparam logic [LEVEL_W-1:0] LEVEL_MUTE = 10'h3FF;
	localparam logic [LEVEL_W-1:0] LEVEL_STEP = 10'h001;
	localparam int ZC_TIMEOUT_FRAMES = 512;
	localparam int ZC_TIMEOUT_MAX_FRAMES = 1024;
	localparam int DB_PER_OCTAVE = 6;
	localparam int GAIN_FRAC_BITS = 8;
	localparam int HPF_SHIFT = 10;
	localparam int DITHER_BITS = 8;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;

	typedef enum logic [1:0] {
		RAMP_IMMEDIATE = 2'h0,
		RAMP_ZERO_CROSS = 2'h1,
		RAMP_SOFT = 2'h2,
		RAMP_SOFT_ZERO_CROSS = 2'h3
	} cvmc_ramp_t;

	typedef enum logic [1:0] {
		MIX_MUTE = 2'h0,
		MIX_RIGHT = 2'h1,
		MIX_LEFT = 2'h2,
		MIX_HALF_SUM = 2'h3
	} cvmc_mix_t;

endpackage

// *** cvmc_volume_mix_regs.sv ***
`timescale 1ns/1ps

module cvmc_volume_mix_regs
	import cvmc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Serial port frame clock
	input wire logic frame_clock,
	// Sample streams
	input wire logic signed [SAMPLE_W-1:0] dac_in_left,
	input wire logic signed [SAMPLE_W-1:0] dac_in_right,
	input wire logic signed [SAMPLE_W-1:0] adc_raw_first,
	input wire logic signed [SAMPLE_W-1:0] adc_raw_second,
	output logic signed [SAMPLE_W-1:0] analog_out_first,
	output logic signed [SAMPLE_W-1:0] analog_out_second,
	output logic signed [SAMPLE_W-1:0] serial_sample_out_first,
	output logic signed [SAMPLE_W-1:0] serial_sample_out_second,
	// Status and pin control
	output logic mute_indicator_first_n,
	output logic mute_indicator_second_n,
	output logic adc_format_select,
	output logic host_port_enable,
	output logic low_power_active
);

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [7:0] mix_ff, att_a_ff, att_b_ff, adc_ff, mode2_ff;
	logic [7:0] eff_mix_ff, eff_att_a_ff, eff_att_b_ff, eff_adc_ff;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mix_ff <= RST_LEVEL_RAMP_AND_MIXING;
			att_a_ff <= RST_CHANNEL_ATTENUATION;
			att_b_ff <= RST_CHANNEL_ATTENUATION;
			adc_ff <= RST_ADC_SETTINGS;
			mode2_ff <= RST_SECOND_MODE_SETTINGS;
		end else if (reg_write) begin
			case (reg_addr)
				ADDR_LEVEL_RAMP_AND_MIXING: mix_ff <= reg_wdata;
				ADDR_CHANNEL_A_ATTENUATION: att_a_ff <= reg_wdata;
				ADDR_CHANNEL_B_ATTENUATION: att_b_ff <= reg_wdata;
				ADDR_ADC_SETTINGS: adc_ff <= reg_wdata;
				ADDR_SECOND_MODE_SETTINGS: mode2_ff <= reg_wdata;
				default: ; // Identity and unmapped writes dropped
			endcase
		end
	end

	// Held copies only follow while freeze is clear, so a release applies all at once
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			eff_mix_ff <= RST_LEVEL_RAMP_AND_MIXING;
			eff_att_a_ff <= RST_CHANNEL_ATTENUATION;
			eff_att_b_ff <= RST_CHANNEL_ATTENUATION;
			eff_adc_ff <= RST_ADC_SETTINGS;
		end else if (!mode2_ff[FREEZE_BIT]) begin
			eff_mix_ff <= mix_ff;
			eff_att_a_ff <= att_a_ff;
			eff_att_b_ff <= att_b_ff;
			eff_adc_ff <= adc_ff;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				ADDR_LEVEL_RAMP_AND_MIXING: reg_rdata <= mix_ff;
				ADDR_CHANNEL_A_ATTENUATION: reg_rdata <= att_a_ff;
				ADDR_CHANNEL_B_ATTENUATION: reg_rdata <= att_b_ff;
				ADDR_ADC_SETTINGS: reg_rdata <= adc_ff;
				ADDR_SECOND_MODE_SETTINGS: reg_rdata <= mode2_ff;
				ADDR_DEVICE_IDENTITY: reg_rdata <= {PART_CODE, REVISION_CODE};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Control decode
	// ----------------------------------------
	// Stand-alone mode ignores the mixing, attenuation and ADC registers and runs their reset defaults; the second mode register still applies
	logic port_on;
	logic [7:0] c_mix, c_att_a, c_att_b, c_adc;
	cvmc_ramp_t ramp_mode;
	logic [7:0] att_byte [2];
	cvmc_mix_t mix_src [2];

	assign port_on = mode2_ff[HOST_PORT_ENABLE_BIT];
	assign c_mix = port_on ? eff_mix_ff : RST_LEVEL_RAMP_AND_MIXING;
	assign c_att_a = port_on ? eff_att_a_ff : RST_CHANNEL_ATTENUATION;
	assign c_att_b = port_on ? eff_att_b_ff : RST_CHANNEL_ATTENUATION;
	assign c_adc = port_on ? eff_adc_ff : RST_ADC_SETTINGS;
	assign ramp_mode = cvmc_ramp_t'(c_mix[RAMP_MODE_MSB:RAMP_MODE_LSB]);
	assign att_byte[0] = c_att_a;
	assign att_byte[1] = c_mix[MIX_LINK_BIT] ? c_att_a : c_att_b;
	assign mix_src[0] = cvmc_mix_t'(c_mix[MIX_A_MSB:MIX_A_LSB]);
	assign mix_src[1] = cvmc_mix_t'(c_mix[MIX_B_MSB:MIX_B_LSB]);

	// ----------------------------------------
	// Frame clock sampling
	// ----------------------------------------
	logic [2:0] fclk_sync_ff;
	logic fclk_level_ff;
	logic frame_tick;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fclk_sync_ff <= 3'h0;
		end else begin
			fclk_sync_ff <= {fclk_sync_ff[1:0], frame_clock};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fclk_level_ff <= 1'b0;
		end else if (fclk_sync_ff[1] == fclk_sync_ff[2]) begin
			fclk_level_ff <= fclk_sync_ff[2];
		end
	end

	// One tick per frame, on the agreed rising level
	assign frame_tick = (fclk_sync_ff[1] == fclk_sync_ff[2]) && fclk_sync_ff[2] && !fclk_level_ff;

	// ----------------------------------------
	// ADC path
	// ----------------------------------------
	logic signed [SAMPLE_W-1:0] adc_raw [2];
	logic signed [SAMPLE_W-1:0] offset_est_ff [2];
	logic signed [SAMPLE_W-1:0] adc_word [2];
	logic [1:0] adc_silence, adc_hold;
	logic [15:0] lfsr_ff;

	assign adc_raw[0] = adc_raw_first;
	assign adc_raw[1] = adc_raw_second;
	assign adc_silence = {c_adc[ADC_SILENCE_FIRST_BIT], c_adc[ADC_SILENCE_SECOND_BIT]};
	assign adc_hold = {c_adc[OFFSET_HOLD_FIRST_BIT], c_adc[OFFSET_HOLD_SECOND_BIT]};

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lfsr_ff <= LFSR_SEED;
		end else if (frame_tick) begin
			lfsr_ff <= (lfsr_ff >> 1) ^ (lfsr_ff[0] ? LFSR_TAPS : 16'h0000);
		end
	end

	// ----------------------------------------
	// DAC level engine, one copy per channel
	// ----------------------------------------
	logic [LEVEL_W-1:0] level_ff [2];
	logic [LEVEL_W-1:0] target [2];
	logic [9:0] zc_count_ff [2];
	logic signed [SAMPLE_W-1:0] prev_mix_ff [2];
	logic signed [SAMPLE_W-1:0] dac_out_ff [2];
	logic signed [SAMPLE_W-1:0] adc_out_ff [2];
	logic signed [SAMPLE_W-1:0] mix_in [2];
	logic signed [SAMPLE_W-1:0] src_left, src_right;
	logic [1:0] zc_seen, zc_allow, chan_muted;

	// Loopback feeds the finished ADC words straight into the mixer
	assign src_left = mode2_ff[LOOPBACK_BIT] ? adc_out_ff[0] : dac_in_left;
	assign src_right = mode2_ff[LOOPBACK_BIT] ? adc_out_ff[1] : dac_in_right;

	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		logic signed [SAMPLE_W:0] sum_lr;
		logic signed [SAMPLE_W:0] hp_diff;
		logic signed [SAMPLE_W-1:0] hp_out;
		logic signed [SAMPLE_W-1:0] dith_word;
		logic [6:0] db;
		logic [4:0] oct_shift;
		logic [2:0] oct_frac;
		logic [8:0] gain_q8;
		logic signed [SAMPLE_W+10:0] prod;

		assign sum_lr = (SAMPLE_W+1)'(src_left) + (SAMPLE_W+1)'(src_right);
		always_comb begin
			case (mix_src[ch])
				MIX_MUTE: mix_in[ch] = '0;
				MIX_RIGHT: mix_in[ch] = src_right;
				MIX_LEFT: mix_in[ch] = src_left;
				MIX_HALF_SUM: mix_in[ch] = sum_lr[SAMPLE_W:1];
				default: mix_in[ch] = '0;
			endcase
		end

		// Mute bit drives the target to the silent level; ramp rules still apply
		assign target[ch] = att_byte[ch][ATT_MUTE_BIT] ? LEVEL_MUTE
			: LEVEL_W'({att_byte[ch][ATT_MSB:0], 3'h0});

		// Either a sign change or touching zero counts as a crossing
		assign zc_seen[ch] = (mix_in[ch] == '0) || (prev_mix_ff[ch] == '0)
			|| (mix_in[ch][SAMPLE_W-1] != prev_mix_ff[ch][SAMPLE_W-1]);
		assign zc_allow[ch] = zc_seen[ch]
			|| (zc_count_ff[ch] == 10'(ZC_TIMEOUT_FRAMES - 1));

		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				prev_mix_ff[ch] <= '0;
			end else if (frame_tick) begin
				prev_mix_ff[ch] <= mix_in[ch];
			end
		end

		// Frames waited for a crossing; cleared once nothing is pending
		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				zc_count_ff[ch] <= '0;
			end else if (level_ff[ch] == target[ch] || zc_allow[ch]) begin
				if (frame_tick) zc_count_ff[ch] <= '0;
			end else if (frame_tick) begin
				zc_count_ff[ch] <= zc_count_ff[ch] + 10'h001;
			end
		end

		// Present level jumps or steps toward the newest target, by ramp mode
		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				level_ff[ch] <= '0;
			end else begin
				case (ramp_mode)
					RAMP_IMMEDIATE: level_ff[ch] <= target[ch];
					RAMP_ZERO_CROSS: begin
						if (frame_tick && zc_allow[ch]) level_ff[ch] <= target[ch];
					end
					RAMP_SOFT, RAMP_SOFT_ZERO_CROSS: begin
						if (frame_tick && (ramp_mode == RAMP_SOFT || zc_allow[ch])) begin
							if (level_ff[ch] < target[ch]) begin
								level_ff[ch] <= level_ff[ch] + LEVEL_STEP;
							end else if (level_ff[ch] > target[ch]) begin
								level_ff[ch] <= level_ff[ch] - LEVEL_STEP;
							end
						end
					end
					default: level_ff[ch] <= target[ch];
				endcase
			end
		end

		// Gain from level: whole octaves by shift, leftover dB from a table
		assign db = level_ff[ch][LEVEL_W-1:3];
		assign oct_shift = 5'(db / 7'(DB_PER_OCTAVE));
		assign oct_frac = 3'(db % 7'(DB_PER_OCTAVE));

		always_comb begin
			case (oct_frac)
				3'h0: gain_q8 = 9'h100;
				3'h1: gain_q8 = 9'h0E4;
				3'h2: gain_q8 = 9'h0CB;
				3'h3: gain_q8 = 9'h0B5;
				3'h4: gain_q8 = 9'h0A2;
				3'h5: gain_q8 = 9'h090;
				default: gain_q8 = 9'h000;
			endcase
		end

		assign prod = (SAMPLE_W+11)'($signed(mix_in[ch]) * $signed({1'b0, gain_q8}))
			>>> (GAIN_FRAC_BITS + oct_shift);

		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				dac_out_ff[ch] <= '0;
			end else if (mode2_ff[LOW_POWER_REQUEST_BIT] || level_ff[ch] == LEVEL_MUTE) begin
				dac_out_ff[ch] <= '0;
			end else if (frame_tick) begin
				dac_out_ff[ch] <= prod[SAMPLE_W-1:0];
			end
		end

		assign chan_muted[ch] = (level_ff[ch] == LEVEL_MUTE);
		// ADC: offset estimate tracks slowly, hold freezes it
		assign hp_diff = (SAMPLE_W+1)'(adc_raw[ch]) - (SAMPLE_W+1)'(offset_est_ff[ch]);
		assign hp_out = SAMPLE_W'(hp_diff);
		assign dith_word = SAMPLE_W'(hp_out + SAMPLE_W'(lfsr_ff[DITHER_BITS-1:0]))
			& ~SAMPLE_W'((1 << DITHER_BITS) - 1);

		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				offset_est_ff[ch] <= '0;
			end else if (frame_tick && !adc_hold[1-ch]) begin
				offset_est_ff[ch] <= offset_est_ff[ch] + SAMPLE_W'(hp_diff >>> HPF_SHIFT);
			end
		end

		assign adc_word[ch] = c_adc[SHORT_WORD_DITHER_BIT] ? dith_word : hp_out;
		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				adc_out_ff[ch] <= '0;
			end else if (adc_silence[1-ch] || mode2_ff[LOW_POWER_REQUEST_BIT]) begin
				adc_out_ff[ch] <= '0;
			end else if (frame_tick) begin
				adc_out_ff[ch] <= adc_word[ch];
			end
		end
	end

	// ----------------------------------------
	// Mute indicators and pin outputs
	// ----------------------------------------
	logic [1:0] mute_req, mute_cond;
	logic linked;

	assign linked = mode2_ff[LINKED_MUTE_INDICATOR_BIT];
	assign mute_req[0] = att_byte[0][ATT_MUTE_BIT] || (linked && att_byte[1][ATT_MUTE_BIT]);
	assign mute_req[1] = att_byte[1][ATT_MUTE_BIT] || (linked && att_byte[0][ATT_MUTE_BIT]);
	assign mute_cond = mute_req & chan_muted;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mute_indicator_first_n <= 1'b1;
			mute_indicator_second_n <= 1'b1;
		end else if (linked) begin
			mute_indicator_first_n <= !(mute_cond[0] && mute_cond[1]);
			mute_indicator_second_n <= !(mute_cond[0] && mute_cond[1]);
		end else begin
			mute_indicator_first_n <= !mute_cond[0];
			mute_indicator_second_n <= !mute_cond[1];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			adc_format_select <= 1'b0;
			host_port_enable <= 1'b0;
			low_power_active <= 1'b1;
		end else begin
			adc_format_select <= c_adc[ADC_FORMAT_BIT];
			host_port_enable <= mode2_ff[HOST_PORT_ENABLE_BIT];
			low_power_active <= mode2_ff[LOW_POWER_REQUEST_BIT];
		end
	end
	assign analog_out_first = dac_out_ff[0];
	assign analog_out_second = dac_out_ff[1];
	assign serial_sample_out_first = adc_out_ff[0];
	assign serial_sample_out_second = adc_out_ff[1];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	identity_read_a: assert property ((reg_addr == ADDR_DEVICE_IDENTITY) |=>
		reg_rdata == {PART_CODE, REVISION_CODE}) else $error("identity readback wrong");
	immediate_level_a: assert property ((ramp_mode == RAMP_IMMEDIATE) |=>
		level_ff[0] == $past(target[0])) else $error("immediate level not applied");
	soft_step_a: assert property ((ramp_mode == RAMP_SOFT && frame_tick
		&& level_ff[0] < target[0]) |=> level_ff[0] == $past(level_ff[0]) + LEVEL_STEP)
		else $error("soft ramp step wrong");
	soft_hold_a: assert property ((ramp_mode == RAMP_SOFT && !frame_tick) |=>
		$stable(level_ff[1])) else $error("level moved off frame");
	zc_wait_a: assert property ((ramp_mode == RAMP_ZERO_CROSS && !zc_allow[1]) |=>
		$stable(level_ff[1])) else $error("change without crossing");
	zc_bound_a: assert property (zc_count_ff[0] < 10'(ZC_TIMEOUT_MAX_FRAMES - 1))
		else $error("timeout overrun");
	freeze_hold_a: assert property (mode2_ff[FREEZE_BIT] |=>
		$stable(eff_att_a_ff)) else $error("frozen setting changed");
	mute_pin_a: assert property ((!linked && mute_cond[0]) |=>
		!mute_indicator_first_n) else $error("mute indicator not active");
	linked_pin_a: assert property ((linked && !(mute_cond[0] && mute_cond[1])) |=>
		mute_indicator_first_n && mute_indicator_second_n) else $error("linked indicator wrong");
	adc_mute_a: assert property ((adc_silence[1]) |=> adc_out_ff[0] == '0)
		else $error("adc not silenced");
	soft_zc_wait_a: assert property ((ramp_mode == RAMP_SOFT_ZERO_CROSS && !zc_allow[0]) |=>
		$stable(level_ff[0])) else $error("step without crossing");
endmodule // cvmc_volume_mix_regs

// *** cvmc_host_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// Host controller on the register port
// ----------------------------------------
module cvmc_host_model
	import cvmc_pkg::*;
(
	// Clock
	input wire logic clock,
	// Register port
	output logic [7:0] reg_addr,
	output logic reg_write,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_write = 1'h0;
		reg_wdata = 8'h00;
	end

	// One strobe cycle, then a free edge so strobes never merge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'h1;
		@(negedge clock);
		reg_write = 1'h0;
		// Released data shows the inverse, never the last value
		reg_wdata = ~d;
	endtask

	// Read data is registered: valid one edge after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		@(negedge clock);
		d = reg_rdata;
	endtask
endmodule // cvmc_host_model

// *** tb_codec_volume_mix_control_regs.sv ***
`timescale 1ns/1ps

module tb_codec_volume_mix_control_regs
	import cvmc_pkg::*;
;
	logic clock, reset_n, frame_clock;
	logic signed [SAMPLE_W-1:0] dl, dr, a1, a2, oa, ob, s1, s2, hv;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
	logic reg_write, ind1_n, ind2_n, fmt, hpe, lpa;
	logic [31:0] seed;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	logic [7:0] addrs [7] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
	logic [7:0] exps [7] = '{8'h29, 8'h00, 8'h00, 8'h00, 8'h01, {PART_CODE, REVISION_CODE}, 8'h00};

	initial begin
		clock = 1'h0;
		forever #20 clock = ~clock;
	end

	// Frame clock unrelated in phase to the system clock
	initial begin
		frame_clock = 1'h0;
		#7;
		forever #160 frame_clock = ~frame_clock;
	end

	cvmc_volume_mix_regs dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.frame_clock(frame_clock), .dac_in_left(dl), .dac_in_right(dr),
		.adc_raw_first(a1), .adc_raw_second(a2), .analog_out_first(oa),
		.analog_out_second(ob), .serial_sample_out_first(s1),
		.serial_sample_out_second(s2), .mute_indicator_first_n(ind1_n),
		.mute_indicator_second_n(ind2_n), .adc_format_select(fmt),
		.host_port_enable(hpe), .low_power_active(lpa));

	cvmc_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_write(reg_write),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	// ----------------------------------------
	// Reference model and helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic signed [23:0] pick(input logic [1:0] c,
		input logic signed [23:0] l, input logic signed [23:0] r);
		logic signed [24:0] sum;
		sum = l + r;
		return c == 2'h0 ? 24'sh000000 : c == 2'h1 ? r : c == 2'h2 ? l : sum[24:1];
	endfunction

	task automatic chk(input logic [23:0] g, input logic [23:0] e, input string m);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask

	task automatic nchk(input logic [23:0] g, input logic [23:0] e, input string m);
		compares++;
		if (g === e) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask

	task automatic fr(input int n);
		repeat (n * 8) @(negedge clock);
	endtask

	// Multiples of 16 keep shifts and half sums exact
	task automatic rnd();
		@(negedge clock);
		seed = lfsr(seed);
		dl = {{4{seed[19]}}, seed[19:4], 4'h0};
		seed = lfsr(lfsr(lfsr(seed)));
		dr = {{4{seed[19]}}, seed[19:4], 4'h0};
		a1 = {2'h1, seed[27:6]};
		a2 = {2'h1, seed[31:10]};
	endtask

	task automatic done(input string n);
		$display("TEST %s done", n);
	endtask

	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Hang guard, well above the longest ramp sequence
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			final_report();
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		reset_n = 1'h0;
		seed = 32'hD650634A;
		dl = '0;
		dr = '0;
		a1 = '0;
		a2 = '0;
		repeat (6) @(negedge clock);
		reset_n = 1'h1;
		chk(hpe, 1'h0, "port enable reset");
		chk(lpa, 1'h1, "low power reset");
		foreach (addrs[i]) begin
			host.rd(addrs[i], rv);
			chk(rv, exps[i], "reset read");
		end
		host.wr(ADDR_DEVICE_IDENTITY, 8'h3C);
		host.rd(ADDR_DEVICE_IDENTITY, rv);
		chk(rv, {PART_CODE, REVISION_CODE}, "identity write");
		done("reset");
		host.wr(ADDR_SECOND_MODE_SETTINGS, 8'h02);
		fr(1);
		chk(hpe, 1'h1, "port enable");
		chk(lpa, 1'h0, "power up");
		for (int m = 0; m < 16; m++) begin
			host.wr(ADDR_LEVEL_RAMP_AND_MIXING, 8'(m));
			rnd();
			fr(4);
			chk(oa, pick(m[3:2], dl, dr), "mix first");
			chk(ob, pick(m[1:0], dl, dr), "mix second");
		end
		done("mix");
		host.wr(ADDR_LEVEL_RAMP_AND_MIXING, 8'h09);
		host.wr(ADDR_CHANNEL_A_ATTENUATION, 8'h06);
		host.wr(ADDR_CHANNEL_B_ATTENUATION, 8'h0C);
		fr(4);
		chk(oa, 24'(dl >>> 1), "atten 6");
		chk(ob, 24'(dr >>> 2), "atten 12");
		host.wr(ADDR_LEVEL_RAMP_AND_MIXING, 8'h49);
		fr(4);
		chk(ob, 24'(dr >>> 1), "channel link");
		host.wr(ADDR_LEVEL_RAMP_AND_MIXING, 8'h09);
		host.wr(ADDR_CHANNEL_A_ATTENUATION, 8'h80);
		fr(3);
		chk(oa, 24'h000000, "mute out");
		chk({ind1_n, ind2_n}, 2'h1, "own indicator");
		host.wr(ADDR_SECOND_MODE_SETTINGS, 8'h0A);
		fr(1);
		chk({ind1_n, ind2_n}, 2'h3, "linked one mute");
		host.wr(ADDR_CHANNEL_B_ATTENUATION, 8'h80);
		fr(3);
		chk({ind1_n, ind2_n}, 2'h0, "linked both");
		host.wr(ADDR_SECOND_MODE_SETTINGS, 8'h02);
		host.wr(ADDR_CHANNEL_A_ATTENUATION, 8'h00);
		host.wr(ADDR_CHANNEL_B_ATTENUATION, 8'h00);
		done("level");
		host.wr(ADDR_LEVEL_RAMP_AND_MIXING, 8'h29);
		fr(4);
		host.wr(ADDR_CHANNEL_A_ATTENUATION, 8'h80);
		fr(500);
		chk(ind1_n, 1'h1, "ramp midway");
		host.wr(ADDR_CHANNEL_A_ATTENUATION, 8'h00);
		fr(400);
		nchk(oa, dl, "ramp back early");
		fr(120);
		chk(oa, dl, "ramp back done");
		host.wr(ADDR_CHANNEL_A_ATTENUATION, 8'h80);
		fr(1030);
		chk(ind1_n, 1'h0, "ramp muted");
		chk(oa, 24'h000000, "ramp out");
		done("soft");
		host.wr(ADDR_LEVEL_RAMP_AND_MIXING, 8'h09);
		host.wr(ADDR_CHANNEL_A_ATTENUATION, 8'h00);
		@(negedge clock);
		dl = 24'sh010000;
		dr = 24'sh000000;
		fr(3);
		host.wr(ADDR_LEVEL_RAMP_AND_MIXING, 8'h19);
		host.wr(ADDR_CHANNEL_A_ATTENUATION, 8'h80);
		host.wr(ADDR_CHANNEL_B_ATTENUATION, 8'h80);
		fr(20);
		chk({ind1_n, ind2_n}, 2'h2, "crossing per channel");
		fr(480);
		chk(oa, dl, "no crossing waits");
		fr(30);
		chk(ind1_n, 1'h0, "timeout applies");
		host.wr(ADDR_LEVEL_RAMP_AND_MIXING, 8'h09);
		host.wr(ADDR_CHANNEL_A_ATTENUATION, 8'h00);
		host.wr(ADDR_LEVEL_RAMP_AND_MIXING, 8'h39);
		host.wr(ADDR_CHANNEL_A_ATTENUATION, 8'h0C);
		fr(100);
		chk(oa, dl, "soft step waits crossing");
		done("zero cross");
		host.wr(ADDR_LEVEL_RAMP_AND_MIXING, 8'h09);
		host.wr(ADDR_CHANNEL_A_ATTENUATION, 8'h00);
		host.wr(ADDR_CHANNEL_B_ATTENUATION, 8'h00);
		@(negedge clock);
		dr = 24'sh020000;
		host.wr(ADDR_SECOND_MODE_SETTINGS, 8'h06);
		host.wr(ADDR_CHANNEL_A_ATTENUATION, 8'h0C);
		host.wr(ADDR_CHANNEL_B_ATTENUATION, 8'h80);
		fr(4);
		chk(oa, dl, "frozen first");
		chk(ob, dr, "frozen second");
		host.wr(ADDR_SECOND_MODE_SETTINGS, 8'h02);
		fr(3);
		chk(oa, 24'(dl >>> 2), "thaw first");
		chk(ob, 24'h000000, "thaw second");
		done("freeze");
		rnd();
		host.wr(ADDR_ADC_SETTINGS, 8'h18);
		fr(3);
		chk(s1, 24'h000000, "adc silence");
		nchk(s2, 24'h000000, "adc other live");
		chk(fmt, 1'h1, "format bit");
		host.wr(ADDR_ADC_SETTINGS, 8'h03);
		fr(2);
		hv = s1;
		fr(20);
		chk(s1, hv, "offset held");
		host.wr(ADDR_ADC_SETTINGS, 8'h00);
		fr(2);
		hv = s1;
		fr(20);
		nchk(s1, hv, "offset tracks");
		host.wr(ADDR_ADC_SETTINGS, 8'h20);
		fr(2);
		chk(s1[7:0], 8'h00, "dither short word");
		chk(fmt, 1'h0, "format left-justified");
		host.wr(ADDR_ADC_SETTINGS, 8'h08);
		host.wr(ADDR_CHANNEL_A_ATTENUATION, 8'h00);
		host.wr(ADDR_SECOND_MODE_SETTINGS, 8'h12);
		fr(4);
		chk(oa, 24'h000000, "loopback");
		done("adc");
		final_report();
	end
endmodule // tb_codec_volume_mix_control_regs
